// File: dv/host_model.sv
// Purpose: Host processor model on the latched port
// Assumes: Strobes idle high, host runs unrelated to core
// Notes: Released data shows inverse of the last word
`default_nettype none
module host_model (
   input  wire logic        sys_clk_i, // Pacing only
   input  wire logic [15:0] bus_i,     // Resolved data lines
   output logic             wr_b_o,    // Write strobe
   output logic             rd_b_o,    // Read strobe
   output logic             sel_o,     // Byte select
   output logic             mode_o,    // Both select pins
   output logic [15:0]      data_o     // Data drive
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {wr_b_o, rd_b_o, sel_o, mode_o} = 4'hF;
      data_o = 16'h5A5A;
   end
   // Both pins always alike
   task automatic set_mode(input logic m);
      mode_o = m;
   endtask
   // Fall, data, rise, then hold past capture
   task automatic put(input logic [15:0] w, input logic s);
      @(posedge sys_clk_i) #2 wr_b_o = 1'b0;
      sel_o = s;
      repeat (2) @(posedge sys_clk_i);
      #2 data_o = w;
      repeat (4) @(posedge sys_clk_i);
      #2 wr_b_o = 1'b1;
      repeat (6) @(posedge sys_clk_i);
      #2 data_o = ~w;
   endtask
   // Low strobe opens the latch; rise completes
   task automatic get(output logic [15:0] w);
      @(posedge sys_clk_i) #2 rd_b_o = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      w = bus_i;
      #2 rd_b_o = 1'b1;
      repeat (6) @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// File: dv/tb_dsp_system_control_and_host_port.sv
// Purpose: Self-checking bench for control register and host port
// Assumes: Design assertions run alongside
// Notes: Serial data, sync inputs and bit clock pin held constant
`include "sysctl_map.svh"
`default_nettype none
module tb_dsp_system_control_and_host_port;
   import sysctl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         sys_clk_i, rst_b_i, ev, irq, frp, xf, oe_sc, full, empty, stat, rdy, ftk, sco;
   logic         wr_b, rd_b, sel, mode, sw, sr;
   logic [15:0]  rdata, hd_o, hd_oe, hd_m, bus, q;
   logic [3:0]   code [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hA, 4'hC};
   int           div [8] = '{32, 28, 24, 20, 16, 14, 12, 10};
   core_req_t    req;
   compand_cfg_t cfg;
   int           n_mismatch = 0, compares = 0, n_sw = 0, n_sr = 0, t0 = 0;
   // Wire level: device where it drives, host elsewhere
   assign bus = (hd_o & ~hd_oe) | (hd_m & hd_oe);
   sysctl_top uut (.sys_clk_i, .rst_b_i, .core_req_i(req), .core_rdata_o(rdata),
      .serial_rdata_i(16'h1234), .serial_wr_o(sw), .serial_rd_o(sr), .compand_cfg_o(cfg),
      .external_event_input(ev), .receive_sync_input(1'b0), .transmit_sync_input(1'b0),
      .core_irq_o(irq), .internal_frame_pulse(frp), .frame_tick_o(ftk), .external_flag_output(xf),
      .sclk_in_i(1'b0), .sclk_out_o(sco), .sclk_oe_b_o(oe_sc), .host_mode_select_pin(mode),
      .standalone_select_pin(mode), .host_wr_b_i(wr_b), .host_rd_b_i(rd_b),
      .latch_byte_select(sel), .host_data_i(bus), .host_data_o(hd_o), .host_data_oe_b_o(hd_oe),
      .rx_latch_empty_flag(empty), .tx_latch_full_flag(full), .polled_status_o(stat),
      .host_wr_ready_o(rdy));
   host_model hm (.sys_clk_i, .bus_i(bus), .wr_b_o(wr_b), .rd_b_o(rd_b), .sel_o(sel),
      .mode_o(mode), .data_o(hd_m));
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      n_sw += (sw === 1'b1);
      n_sr += (sr === 1'b1);
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One-cycle strobe; read data sampled inside the cycle
   task automatic core(input logic w, input logic [2:0] p, input logic [15:0] d);
      @(posedge sys_clk_i) #2 req = '{w, ~w, p, d};
      #1 q = rdata;
      @(posedge sys_clk_i) #2 req = '0;
   endtask
   // First pulse may straddle a reprogram, so it is skipped
   task automatic frame(input int per, input int wid);
      int n, w;
      w = 0;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         while (frp !== 1'b1) begin
            @(posedge sys_clk_i);
            n++;
         end
         if (k == 2) check("frame_period", n + w, per);
         w = 0;
         while (frp === 1'b1) begin
            @(posedge sys_clk_i);
            w++;
         end
      end
      check("frame_width", w, wid);
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      n_mismatch++;
      wrap_up;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rst_b_i, ev} = 2'b00;
      req = '0;
      repeat (5) @(posedge sys_clk_i);
      #2 rst_b_i = 1'b1;
      core(1'b0, `PORT_CTRL_LOW, 16'h0000);
      check("ctrl_low_reset", q[15:4], 12'h000);
      check("latch_flags_reset", {empty, full, stat}, 3'b101);
      core(1'b1, `PORT_CTRL_LOW, 16'hFC10);
      check("cfg_flag_sclk", {cfg, xf, oe_sc}, 7'h5F);
      @(posedge sys_clk_i) #2 ev = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      check("irq_unmasked", irq, 1'b1);
      core(1'b0, `PORT_CTRL_LOW, 16'h0000);
      check("flag_set", q[0], 1'b1);
      core(1'b1, `PORT_CTRL_LOW, 16'hFC11);
      core(1'b0, `PORT_CTRL_LOW, 16'h0000);
      check("flag_cleared", {q[0], irq}, 2'b00);
      core(1'b1, `PORT_CTRL_HIGH, 16'h00AA);
      core(1'b0, `PORT_CTRL_HIGH, 16'h0000);
      check("port1_serial", {q, n_sw[1:0], n_sr[1:0]}, {16'h1234, 4'h5});
      core(1'b1, `PORT_CTRL_LOW, 16'h0100);
      check("sclk_drive", oe_sc, 1'b0);
      foreach (div[i]) begin
         core(1'b1, `PORT_CTRL_HIGH, {4'h4, code[i], 8'h08});
         frame(10 * div[i], div[i]);
      end
      core(1'b0, `PORT_CTRL_HIGH, 16'h0000);
      check("ctrl_high", q, 16'h4C08);
      core(1'b1, `PORT_CTRL_HIGH, 16'h7C08);
      frame(100, 80);
      check("twos", cfg.twos, 1'b1);
      @(negedge sco) t0 = int'($time);
      @(posedge sco) check("sclk_low", int'($time) - t0, 100);
      wait (frp === 1'b1);
      #1 check("frame_tick_int", ftk, 1'b1);
      core(1'b1, `PORT_CTRL_LOW, 16'h0300);
      wait (frp === 1'b1);
      #1 check("frame_tick_ext", ftk, 1'b0);
      @(posedge sys_clk_i) #2 ev = 1'b0;
      hm.set_mode(1'b0);
      core(1'b1, `PORT_HOST, 16'hC3A5);
      check("tx_full", {full, stat}, 2'b11);
      hm.get(q);
      check("host_read", {q, hd_oe, full, stat}, {16'hC3A5, 16'hFFFF, 2'b00});
      for (int i = 0; i < 16; i++) hm.put(16'h0A00 + 16'(i), 1'b0);
      check("wr_fifo_full", {empty, irq, rdy}, 3'b010);
      for (int i = 0; i < 16; i++) begin
         core(1'b0, `PORT_HOST, 16'h0000);
         check("rx_word", q, 16'h0A00 + 16'(i));
      end
      repeat (2) @(posedge sys_clk_i);
      check("rx_drained", {empty, irq, rdy}, 3'b101);
      core(1'b1, `PORT_CTRL_HIGH, 16'h1C08);
      hm.put(16'hFF12, 1'b1);
      hm.put(16'hEE34, 1'b0);
      core(1'b0, `PORT_HOST, 16'h0000);
      check("byte_word", q, 16'h1234);
      wrap_up;
   end
endmodule
`default_nettype wire

// File: rtl/sysctl_fifo.sv
// Purpose : Small valid/ready FIFO for host-written words
// Assumes : Single clock
// Notes   : Full and empty come from a count
`default_nettype none
module sysctl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk_i,  // Clock
   input  wire logic             rst_b_i,    // Async reset, low
   input  wire logic             in_valid_i, // Write valid
   output logic                  in_ready_o, // Not full
   input  wire logic [WIDTH-1:0] in_data_i,  // Write data
   output logic                  out_valid_o,// Not empty
   input  wire logic             out_ready_i,// Drain
   output logic      [WIDTH-1:0] out_data_o  // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;
   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;
   assign out_data_o = mem[rp_r];
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wp_r] <= in_data_i;
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// File: rtl/sysctl_map.svh
// Purpose : Register offsets, field positions, reset values and counts
// Assumes : Core I/O port numbers select registers; 16-bit core data
// Notes on behaviour
// R01 - Port 0 low bits, port 1 high/data
// R02 - Four event flags, write-one clears
// R03 - Bits 4-7 mask events to interrupt
// R04 - Bit 8 steers port 1 access
// R05 - Bit 9 picks internal or external framing
// R06 - Bit 10 drives external flag pin
// R07 - Bit 11 serial versus parallel companding
// R08 - Bit 12 enables encoder on writes
// R09 - Bit 13 enables decoder on reads
// R10 - Bit 14 selects A-law or mu-law
// R11 - Bit 15 bit clock input or output
// R12 - Frame pulse every modulus plus two clocks
// R13 - Software keeps modulus above 7, not ones
// R14 - Prescaler bits 27-24 choose clock divide
// R15 - Bit 28 frame pulse one or eight
// R16 - Bit 29 selects two's-complement format
// R17 - Software writes zero to bit 31
// R18 - Host port only with both selects low
// R19 - Bit 30 selects sixteen-bit host latch
// R20 - Byte select addresses latch halves
// R21 - Host write: fall clears empty, rise captures
// R22 - Core read sets empty, clears latch
// R23 - Host read rise raises polled status; the code drives polled_status_o low on that rise
// R24 - Outside keeps event and status undriven
// R25 - Host strobes synchronised before use; data drive enable uses raw host_rd_b_i
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH
`define PORT_CTRL_LOW     3'h0
`define PORT_CTRL_HIGH    3'h1
`define PORT_HOST         3'h5
`define BIT_PORT1_CFG     8
`define BIT_EXT_FRAME     9
`define BIT_EXT_FLAG      10
`define BIT_SERIAL_EN     11
`define BIT_ENC_EN        12
`define BIT_DEC_EN        13
`define BIT_ALAW          14
`define BIT_SCLK_IN       15
`define BIT_FR_WIDE       12
`define BIT_TWOS          13
`define BIT_HOST_WIDE     14
`define CTRL_LOW_RESET    16'h0000
`define CTRL_HIGH_RESET   16'h0000
`define FR_WIDE_CYCLES    4'h8
`define FIFO_DEPTH        16
`endif

// File: rtl/sysctl_pkg.sv
// Purpose : Shared types for the system control block
// Assumes : Map header holds the numbers
// Notes   : Structs carry grouped core bus fields and companding settings
`default_nettype none
package sysctl_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  port;
      logic [15:0] data;
   } core_req_t;
   typedef struct packed {
      logic        alaw;
      logic        twos;
      logic        enc_en;
      logic        dec_en;
      logic        serial_en;
   } compand_cfg_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW  = 2'b01,
      HS_HIGH = 2'b10
   } host_strobe_t;
endpackage
`default_nettype wire

// File: rtl/sysctl_top.sv
// Purpose : System control register, timing logic and host latch port
// Assumes : Core accesses are one-cycle strobes; host strobes asynchronous
// Notes   : Serial shift and companding arithmetic live elsewhere
`include "sysctl_map.svh"
`default_nettype none
module sysctl_top
   import sysctl_pkg::*;
(
   input  wire logic         sys_clk_i,         // Device clock, 50 MHz
   input  wire logic         rst_b_i,           // Async reset, low
   input  wire core_req_t    core_req_i,        // Core IN/OUT access
   output logic [15:0]       core_rdata_o,      // Core read data
   input  wire logic [15:0]  serial_rdata_i,    // Serial/compand read data
   output logic              serial_wr_o,       // Port 1 write to serial path
   output logic              serial_rd_o,       // Port 1 read from serial path
   output compand_cfg_t      compand_cfg_o,     // Companding settings
   input  wire logic         external_event_input, // External event
   input  wire logic         receive_sync_input,   // Receive sync
   input  wire logic         transmit_sync_input,  // Transmit sync
   output logic              core_irq_o,        // Interrupt to core
   output logic              internal_frame_pulse, // Frame pulse output
   output logic              frame_tick_o,      // Active frame for transfers
   output logic              external_flag_output, // Flag pin
   input  wire logic         sclk_in_i,         // Bit clock pin input
   output logic              sclk_out_o,        // Bit clock pin output
   output logic              sclk_oe_b_o,       // Bit clock drive, low = drive
   input  wire logic         host_mode_select_pin, // Mode select
   input  wire logic         standalone_select_pin,// Mode select twin
   input  wire logic         host_wr_b_i,       // Host write strobe
   input  wire logic         host_rd_b_i,       // Host read strobe
   input  wire logic         latch_byte_select, // High/low byte
   input  wire logic [15:0]  host_data_i,       // Host data in
   output logic [15:0]       host_data_o,       // Output latch
   output logic [15:0]       host_data_oe_b_o,  // Data drive, low = drive
   output logic              rx_latch_empty_flag, // Receive latch empty
   output logic              tx_latch_full_flag,  // Transmit latch full
   output logic              polled_status_o,   // Status to core
   output logic              host_wr_ready_o    // Host latch can accept
);
   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   logic [15:0] ctrl_low_r;
   logic [15:0] ctrl_high_r;
   logic [3:0]  flag_r;
   logic [3:0]  event_set;
   logic        host_mode;
   logic        host_irq;
   logic        wr0;
   logic        wr1_ctrl;
   logic        rd5;
   logic        wr5;
   assign wr0      = core_req_i.wr && core_req_i.port == `PORT_CTRL_LOW;     // [R01]
   assign wr1_ctrl = core_req_i.wr && core_req_i.port == `PORT_CTRL_HIGH
                     && ctrl_low_r[`BIT_PORT1_CFG];                          // [R04]
   assign host_mode = !host_mode_select_pin && !standalone_select_pin;      // [R18]
   assign rd5 = core_req_i.rd && core_req_i.port == `PORT_HOST && host_mode;
   assign wr5 = core_req_i.wr && core_req_i.port == `PORT_HOST && host_mode;
   assign serial_wr_o = core_req_i.wr && core_req_i.port == `PORT_CTRL_HIGH
                        && !ctrl_low_r[`BIT_PORT1_CFG];                     // [R04]
   assign serial_rd_o = core_req_i.rd && core_req_i.port == `PORT_CTRL_HIGH
                        && !ctrl_low_r[`BIT_PORT1_CFG];

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_low_r <= `CTRL_LOW_RESET;
      end else if (wr0) begin
         ctrl_low_r <= {core_req_i.data[15:4], 4'h0};
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_high_r <= `CTRL_HIGH_RESET;
      end else if (wr1_ctrl) begin
         ctrl_high_r <= core_req_i.data; // Bit 31 kept as written [R17]
      end
   end
   // Set wins over a same-cycle write-one clear
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_r <= 4'h0;
      end else begin
         flag_r <= (flag_r & ~(wr0 ? core_req_i.data[3:0] : 4'h0)) | event_set; // [R02]
      end
   end
   assign core_irq_o = |(flag_r & ctrl_low_r[7:4]) || host_irq;             // [R03]

   assign external_flag_output = ctrl_low_r[`BIT_EXT_FLAG];                 // [R06]
   assign compand_cfg_o.serial_en = ctrl_low_r[`BIT_SERIAL_EN];             // [R07]
   assign compand_cfg_o.enc_en    = ctrl_low_r[`BIT_ENC_EN];                // [R08]
   assign compand_cfg_o.dec_en    = ctrl_low_r[`BIT_DEC_EN];                // [R09]
   assign compand_cfg_o.alaw      = ctrl_low_r[`BIT_ALAW];                  // [R10]
   assign compand_cfg_o.twos      = ctrl_high_r[`BIT_TWOS];                 // [R16]

   // ---------------------------------------------------------------
   // Event edge detection
   // ---------------------------------------------------------------
   logic [3:0] ev_now;
   logic [3:0] ev_prev_r;
   logic       fr_rise;
   // In host mode the external event line is owned by the port
   assign ev_now = {1'b0, transmit_sync_input, receive_sync_input,
                    external_event_input && !host_mode};                    // [R24]
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ev_prev_r <= 4'h0;
      end else begin
         ev_prev_r <= ev_now;
      end
   end
   assign event_set = (ev_now & ~ev_prev_r) | {fr_rise, 3'b000};

   // ---------------------------------------------------------------
   // Bit clock prescaler
   // ---------------------------------------------------------------
   logic [4:0] half_div;
   logic [4:0] pre_cnt_r;
   logic       sclk_r;
   logic       sclk_in_s_r;
   logic       sclk_tick;
   always_comb begin
      unique case (ctrl_high_r[11:8])                                      // [R14]
         4'h0:    half_div = 5'h10;
         4'h1:    half_div = 5'h0E;
         4'h2:    half_div = 5'h0C;
         4'h4:    half_div = 5'h0A;
         4'h8:    half_div = 5'h08;
         4'h9:    half_div = 5'h07;
         4'hA:    half_div = 5'h06;
         4'hC:    half_div = 5'h05;
         default: half_div = 5'h10;
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_cnt_r <= 5'h00;
         sclk_r    <= 1'b0;
      end else if (pre_cnt_r >= half_div - 5'h01) begin
         pre_cnt_r <= 5'h00;
         sclk_r    <= !sclk_r;
      end else begin
         pre_cnt_r <= pre_cnt_r + 5'h01;
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_in_s_r <= 1'b0;
      end else begin
         sclk_in_s_r <= sclk_in_i;
      end
   end
   assign sclk_out_o  = sclk_r;
   assign sclk_oe_b_o = ctrl_low_r[`BIT_SCLK_IN];                           // [R11]
   // One enable per bit clock rising edge, either direction
   assign sclk_tick = ctrl_low_r[`BIT_SCLK_IN] ? (sclk_in_i && !sclk_in_s_r)
                    : (!sclk_r && pre_cnt_r >= half_div - 5'h01);          // [R11]

   // ---------------------------------------------------------------
   // Frame counter
   // ---------------------------------------------------------------
   logic [8:0] frm_cnt_r;
   logic [3:0] fr_len_r;
   logic       fr_r;
   logic       fr_prev_r;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frm_cnt_r <= 9'h000;
         fr_len_r  <= 4'h0;
         fr_r      <= 1'b0;
      end else if (sclk_tick) begin
         if (frm_cnt_r >= {1'b0, ctrl_high_r[7:0]} + 9'h001) begin          // [R12]
            frm_cnt_r <= 9'h000;
            fr_r      <= 1'b1;
            fr_len_r  <= ctrl_high_r[`BIT_FR_WIDE] ? `FR_WIDE_CYCLES : 4'h1; // [R15]
         end else begin
            frm_cnt_r <= frm_cnt_r + 9'h001;
            if (fr_len_r <= 4'h1) begin
               fr_r     <= 1'b0;
               fr_len_r <= 4'h0;
            end else begin
               fr_len_r <= fr_len_r - 4'h1;
            end
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fr_prev_r <= 1'b0;
      end else begin
         fr_prev_r <= fr_r;
      end
   end
   assign fr_rise = fr_r && !fr_prev_r;
   assign internal_frame_pulse = fr_r;
   assign frame_tick_o = ctrl_low_r[`BIT_EXT_FRAME]
                         ? (transmit_sync_input || receive_sync_input) : fr_r; // [R05]

   // ---------------------------------------------------------------
   // Host latch port
   // ---------------------------------------------------------------
   logic [1:0]  wr_sync_r;
   logic [1:0]  rd_sync_r;
   logic        wr_prev_r;
   logic        rd_prev_r;
   logic        wr_fall;
   logic        wr_rise;
   logic        rd_rise;
   logic [15:0] rx_latch_r;
   logic [15:0] tx_latch_r;
   logic        rx_empty_r;
   logic        tx_full_r;
   logic        irq_r;
   logic        status_r;
   logic        fifo_out_valid;
   logic        fifo_in_ready;
   logic [15:0] fifo_out_data;
   logic        wide;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_sync_r <= 2'b11;
         rd_sync_r <= 2'b11;
         wr_prev_r <= 1'b1;
         rd_prev_r <= 1'b1;
      end else begin
         wr_sync_r <= {wr_sync_r[0], host_wr_b_i};                          // [R25]
         rd_sync_r <= {rd_sync_r[0], host_rd_b_i};
         wr_prev_r <= wr_sync_r[1];
         rd_prev_r <= rd_sync_r[1];
      end
   end
   assign wr_fall = host_mode && wr_prev_r && !wr_sync_r[1];
   assign wr_rise = host_mode && !wr_prev_r && wr_sync_r[1];
   assign rd_rise = host_mode && !rd_prev_r && rd_sync_r[1];
   assign wide = ctrl_high_r[`BIT_HOST_WIDE];                               // [R19]

   // Data captured at the synchronised rise; host holds data past it
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_latch_r <= 16'h0000;
      end else if (wr_rise) begin                                           // [R21]
         if (wide) begin
            rx_latch_r <= host_data_i;
         end else if (latch_byte_select) begin                               // [R20]
            rx_latch_r[15:8] <= host_data_i[7:0];
         end else begin
            rx_latch_r[7:0] <= host_data_i[7:0];
         end
      end else if (rd5) begin
         rx_latch_r <= 16'h0000;                                            // [R22]
      end
   end
   // Whole words go to the FIFO once the last half arrives
   logic push_word;
   assign push_word = wr_rise && (wide || !latch_byte_select);
   logic [15:0] push_data;
   assign push_data = wide ? host_data_i : {rx_latch_r[15:8], host_data_i[7:0]};
   assign host_wr_ready_o = fifo_in_ready;

   sysctl_fifo #(
      .WIDTH (16),
      .DEPTH (`FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push_word),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (rd5),
      .out_data_o  (fifo_out_data)
   );

   // Empty flag low means data pending; fall clears, core read sets
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_empty_r <= 1'b1;
         irq_r      <= 1'b0;
      end else begin
         if (wr_fall) begin
            rx_empty_r <= 1'b0;                                             // [R21]
         end else if (rd5 && !(fifo_out_valid && push_word)) begin
            rx_empty_r <= 1'b1;                                             // [R22]
         end
         if (push_word) begin
            irq_r <= 1'b1;                                                  // [R21]
         end else if (rd5) begin
            irq_r <= 1'b0;                                                  // [R22]
         end
      end
   end
   assign host_irq = irq_r;
   assign rx_latch_empty_flag = rx_empty_r;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_latch_r <= 16'h0000;
         tx_full_r  <= 1'b0;
         status_r   <= 1'b1;
      end else begin
         if (wr5) begin
            tx_latch_r <= core_req_i.data;
            tx_full_r  <= 1'b1;
            status_r   <= 1'b1;
         end else if (rd_rise && (wide || !latch_byte_select)) begin
            tx_full_r <= 1'b0;
            status_r  <= 1'b0;                                              // [R23]
         end
      end
   end
   assign tx_latch_full_flag = tx_full_r;
   assign polled_status_o = status_r; // Active low, like the pin
   assign host_data_o = wide ? tx_latch_r
                        : {8'h00, latch_byte_select ? tx_latch_r[15:8] : tx_latch_r[7:0]};
   // Drive only while the host read strobe is low in host mode
   assign host_data_oe_b_o = (host_mode && !host_rd_b_i)
                             ? (wide ? 16'h0000 : 16'hFF00) : 16'hFFFF;     // [R23]

   // ---------------------------------------------------------------
   // Core read mux
   // ---------------------------------------------------------------
   always_comb begin
      core_rdata_o = 16'h0000;
      if (core_req_i.port == `PORT_CTRL_LOW) begin
         core_rdata_o = {ctrl_low_r[15:4], flag_r};                         // [R01]
      end else if (core_req_i.port == `PORT_CTRL_HIGH) begin
         core_rdata_o = ctrl_low_r[`BIT_PORT1_CFG] ? ctrl_high_r : serial_rdata_i; // [R04]
      end else if (core_req_i.port == `PORT_HOST && host_mode) begin
         core_rdata_o = fifo_out_data;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_flag_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R02]
      event_set[0] |=> flag_r[0]) else $error("event flag lost");
   chk_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R02]
      (wr0 && core_req_i.data[0] && !event_set[0]) |=> !flag_r[0])
      else $error("flag not cleared");
   chk_mask_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R03]
      (flag_r[0] && ctrl_low_r[4]) |-> core_irq_o) else $error("masked irq missing");
   chk_flag_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R06]
      wr0 |=> external_flag_output == $past(core_req_i.data[10]))
      else $error("flag pin wrong");
   chk_sclk_dir: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R11]
      (sclk_tick && !ctrl_low_r[15] && !wr0) |=> (sclk_out_o && !sclk_oe_b_o))
      else $error("bit clock direction");
   chk_fr_narrow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R15]
      ($rose(fr_r) && !ctrl_high_r[12]) |-> fr_len_r == 4'h1)
      else $error("narrow frame length");
   chk_host_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R18]
      !host_mode |-> (host_data_oe_b_o == 16'hFFFF && !wr_rise))
      else $error("host port active");
   chk_wr_irq: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R21]
      push_word |=> host_irq) else $error("host write irq");
   chk_read_empty: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R22]
      (rd5 && !wr_fall && !push_word) |=> rx_latch_empty_flag && !host_irq)
      else $error("core read empty");
   chk_rd_status: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R23]
      (rd_rise && wide && !wr5) |=> !polled_status_o) else $error("status");
endmodule
`default_nettype wire
